// ==== rtl/cip_core_irq_controller.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Grant if above the running level, else keep pending.
// - After return, one instruction runs before a grant.
// - Entry leaves the flag set; software clears it.
// - Maskable grants need global enable at one.
// - A source requests only when enabled and triggered.
// - vector_base_select picks the table base.
// - Zero: application base; one: boot base.
// - Entry: finish one, push two, jump three or two cycles.
// - Multi-cycle instructions complete before entry.
// - Wake adds five cycles plus start-up time.
// - Return takes four or five cycles.
// - Levels: non-maskable, one level 1 vector, rest level 0.
// - Level 1 preempts level 0, which then resumes.
// - Non-maskable ignores and keeps global enable.
// - Nothing preempts a non-maskable handler.
// - Lowest non-maskable vector wins.
// - Non-maskable set is fixed but needs its enable.
// - high_level_vector_reg names the level 1 vector.
// - rotate_priority_enable makes level 0 rotate.
// - Fixed: lowest wins; stored Y makes Y+1 highest.
// - Rotating: last level 0 grant stored as lowest.
// - Compact table: vectors 1, 2, 3 by level.
module cip_core_irq_controller
    import cip_pkg::*;
#(
    parameter int N_SRC = 16,
    parameter logic [31:0] NMI_MASK = 32'h00000001,
    parameter int FLASH_KB = 32,
    parameter int PC_BITS = 16,
    parameter int ADDR_W = 16,
    parameter logic [15:0] APP_BASE = 16'h0000,
    parameter logic [15:0] BOOT_BASE = 16'h0000,
    parameter logic [15:0] SU_IDLE_CYC = 16'h0000,
    parameter logic [15:0] SU_STANDBY_CYC = 16'h0004,
    parameter logic [15:0] SU_PDOWN_CYC = 16'h0008
)(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [N_SRC-1:0] irq_cond, // Peripheral condition events
    input wire logic insn_done, // Core finished an instruction
    input wire logic core_sleeping, // Core is asleep
    input wire logic [1:0] sleep_mode, // Selected sleep mode
    input wire logic return_from_irq, // Core executed a return
    output logic core_hold, // Core stalled by entry or return sequence
    output logic irq_enter, // Pulse: core jumps to handler_addr
    output logic [ADDR_W-1:0] handler_addr, // Handler vector address
    output logic [7:0] irq_vector, // Vector number taken
    output logic [1:0] irq_level // Level of vector taken
);

    localparam int IDXW = (N_SRC > 1) ? $clog2(N_SRC) : 1;
    localparam logic [N_SRC-1:0] NMI_SET = NMI_MASK[N_SRC-1:0];
    localparam int JUMP_CYC = (FLASH_KB > SHORT_JUMP_MAX_KB) ? JUMP_LONG_CYC : JUMP_SHORT_CYC;
    localparam int RET_CYC = (PC_BITS > 16) ? RET_LONG_CYC : RET_SHORT_CYC;
    localparam logic [ADDR_W-1:0] VEC_STEP = (FLASH_KB > SHORT_JUMP_MAX_KB) ? ADDR_W'(2) : ADDR_W'(1);

    // Search starts at index y (vector y+1), wrapping
    function automatic logic [IDXW:0] pick_rot(input logic [N_SRC-1:0] r, input logic [7:0] y);
        logic [IDXW:0] res;
        int v;
        res = '0;
        for (int k = 0; k < N_SRC; k++)
        begin
            v = (int'(y) + k) % N_SRC;
            if (!res[IDXW] && r[v])
                res = {1'b1, IDXW'(v)};
        end
        return res;
    endfunction

    function automatic logic [31:0] byte_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    cip_state_t state_q;
    logic [15:0] cnt_q;
    logic [7:0] ctrl_q;
    logic [7:0] l0pri_q;
    logic [7:0] l1vec_q;
    logic [7:0] core_stat_q;
    logic [N_SRC-1:0] src_en_q;
    logic [N_SRC-1:0] flags_q;
    logic nmi_ex_q;
    logic l1_ex_q;
    logic l0_ex_q;
    logic [IDXW-1:0] sel_idx_q;
    cip_level_t sel_lvl_q;
    logic irq_enter_q;
    logic [ADDR_W-1:0] handler_addr_q;
    logic [7:0] irq_vector_q;
    logic [1:0] irq_level_q;

    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // One write and one read at a time
    logic do_wr;
    logic [2:0] wr_idx;
    logic wr_ok;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [2:0] rd_idx;
    logic rd_ok;
    logic [31:0] rd_val;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_idx = awaddr_q[4:2];
    assign wr_ok = (awaddr_q[7:5] == 3'h0) && (awaddr_q[1:0] == 2'h0);
    assign wmask = byte_mask(wstrb_q);
    assign wval = wdata_q & wmask;
    assign rd_idx = s_axi_araddr[4:2];
    assign rd_ok = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);

    function automatic logic wr_hit(input logic [2:0] idx);
        return do_wr && wr_ok && (wr_idx == idx) && wstrb_q[0];
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (do_wr)
            aw_hold_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (do_wr)
            w_hold_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (do_wr)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    always_comb
    begin
        rd_val = 32'h00000000;
        unique case (rd_idx)
            IDX_CTRL: rd_val[7:0] = ctrl_q;
            IDX_STATUS:
            begin
                rd_val[STAT_NMI_BIT] = nmi_ex_q;
                rd_val[STAT_L1_BIT] = l1_ex_q;
                rd_val[STAT_L0_BIT] = l0_ex_q;
            end
            IDX_L0PRI: rd_val[7:0] = l0pri_q;
            IDX_L1VEC: rd_val[7:0] = l1vec_q;
            IDX_CORE_STAT: rd_val[7:0] = core_stat_q;
            IDX_SRC_EN: rd_val[N_SRC-1:0] = src_en_q;
            IDX_FLAGS: rd_val[N_SRC-1:0] = flags_q;
            IDX_ENGINE: rd_val[6:0] = state_q;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_val : 32'h00000000;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // Arbitration
    logic [N_SRC-1:0] req;
    logic [N_SRC-1:0] nmi_req;
    logic [N_SRC-1:0] l1_req;
    logic [N_SRC-1:0] l0_req;
    logic [IDXW:0] nmi_pick;
    logic [IDXW:0] l1_pick;
    logic [IDXW:0] l0_pick;
    logic gie;
    logic grant_nmi;
    logic grant_l1;
    logic grant_l0;
    logic grant_any;

    assign req = flags_q & src_en_q;
    assign gie = core_stat_q[CORE_I_BIT];

    for (genvar i = 0; i < N_SRC; i++)
    begin : g_lvl
        localparam logic [7:0] VEC = 8'(i + 1);
        assign nmi_req[i] = req[i] && NMI_SET[i];
        assign l1_req[i] = req[i] && !NMI_SET[i] && (l1vec_q == VEC);
        assign l0_req[i] = req[i] && !NMI_SET[i] && (l1vec_q != VEC);
    end

    assign nmi_pick = pick_rot(nmi_req, 8'h00);
    assign l1_pick = pick_rot(l1_req, 8'h00);
    assign l0_pick = pick_rot(l0_req, l0pri_q);

    // A running NMI handler blocks everything; level 1 blocks level 0
    assign grant_nmi = nmi_pick[IDXW] && !nmi_ex_q;
    assign grant_l1 = l1_pick[IDXW] && gie && !nmi_ex_q && !l1_ex_q;
    assign grant_l0 = l0_pick[IDXW] && gie && !nmi_ex_q && !l1_ex_q && !l0_ex_q;
    assign grant_any = grant_nmi || grant_l1 || grant_l0;

    // Entry and return sequencer
    logic [15:0] wake_cyc;
    always_comb
    begin
        unique case (sleep_mode)
            SLP_IDLE: wake_cyc = SU_IDLE_CYC;
            SLP_STANDBY: wake_cyc = SU_STANDBY_CYC;
            SLP_PDOWN: wake_cyc = SU_PDOWN_CYC;
            default: wake_cyc = SU_PDOWN_CYC;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (return_from_irq)
                    begin
                        state_q <= ST_RET;
                        cnt_q <= 16'(RET_CYC - 1);
                    end
                    else if (grant_any)
                        state_q <= ST_FINISH;
                end
                ST_FINISH:
                begin
                    // Done also covers multi-cycle instructions
                    if (core_sleeping)
                    begin
                        state_q <= ST_WAKE;
                        cnt_q <= 16'(WAKE_EXTRA_CYC - 1) + wake_cyc;
                    end
                    else if (insn_done)
                    begin
                        state_q <= ST_PUSH;
                        cnt_q <= 16'(PUSH_CYC - 1);
                    end
                end
                ST_WAKE:
                begin
                    if (cnt_q == 16'h0000)
                    begin
                        state_q <= ST_PUSH;
                        cnt_q <= 16'(PUSH_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_PUSH:
                begin
                    if (cnt_q == 16'h0000)
                    begin
                        state_q <= ST_JUMP;
                        cnt_q <= 16'(JUMP_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_JUMP:
                begin
                    if (cnt_q == 16'h0000)
                        state_q <= ST_IDLE;
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_RET:
                begin
                    if (cnt_q == 16'h0000)
                        state_q <= ST_RESUME;
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_RESUME:
                begin
                    if (insn_done)
                        state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign core_hold = (state_q == ST_WAKE) || (state_q == ST_PUSH) || (state_q == ST_JUMP) || (state_q == ST_RET);

    // Winner frozen so a late request cannot swap it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_idx_q <= '0;
            sel_lvl_q <= LVL_L0;
        end
        else if (state_q == ST_IDLE && !return_from_irq && grant_any)
        begin
            if (grant_nmi)
            begin
                sel_idx_q <= nmi_pick[IDXW-1:0];
                sel_lvl_q <= LVL_NMI;
            end
            else if (grant_l1)
            begin
                sel_idx_q <= l1_pick[IDXW-1:0];
                sel_lvl_q <= LVL_L1;
            end
            else
            begin
                sel_idx_q <= l0_pick[IDXW-1:0];
                sel_lvl_q <= LVL_L0;
            end
        end
    end

    logic entering;
    logic returned;
    assign entering = (state_q == ST_JUMP) && (cnt_q == 16'h0000);
    assign returned = (state_q == ST_RET) && (cnt_q == 16'h0000);

    // Executing flags act as the level stack
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nmi_ex_q <= 1'b0;
            l1_ex_q <= 1'b0;
            l0_ex_q <= 1'b0;
        end
        else if (state_q == ST_FINISH && (insn_done || core_sleeping))
        begin
            nmi_ex_q <= nmi_ex_q || (sel_lvl_q == LVL_NMI);
            l1_ex_q <= l1_ex_q || (sel_lvl_q == LVL_L1);
            l0_ex_q <= l0_ex_q || (sel_lvl_q == LVL_L0);
        end
        else if (returned)
        begin
            if (nmi_ex_q)
                nmi_ex_q <= 1'b0;
            else if (l1_ex_q)
                l1_ex_q <= 1'b0;
            else
                l0_ex_q <= 1'b0;
        end
    end

    logic [7:0] sel_vec;
    logic [7:0] out_vec;
    assign sel_vec = 8'(sel_idx_q) + 8'h01;

    always_comb
    begin
        out_vec = sel_vec;
        if (ctrl_q[CTRL_CVT_BIT])
        begin
            unique case (sel_lvl_q)
                LVL_NMI: out_vec = CVT_NMI_VEC;
                LVL_L1: out_vec = CVT_L1_VEC;
                default: out_vec = CVT_L0_VEC;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_enter_q <= 1'b0;
            handler_addr_q <= '0;
            irq_vector_q <= 8'h00;
            irq_level_q <= 2'h0;
        end
        else
        begin
            irq_enter_q <= entering;
            if (entering)
            begin
                handler_addr_q <= (ctrl_q[CTRL_VSEL_BIT] ? ADDR_W'(BOOT_BASE) : ADDR_W'(APP_BASE))
                    + ADDR_W'(out_vec) * VEC_STEP;
                irq_vector_q <= out_vec;
                irq_level_q <= sel_lvl_q;
            end
        end
    end

    assign irq_enter = irq_enter_q;
    assign handler_addr = handler_addr_q;
    assign irq_vector = irq_vector_q;
    assign irq_level = irq_level_q;

    // Configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= CTRL_RST;
        else if (wr_hit(IDX_CTRL))
        begin
            ctrl_q[CTRL_VSEL_BIT] <= wdata_q[CTRL_VSEL_BIT];
            ctrl_q[CTRL_CVT_BIT] <= wdata_q[CTRL_CVT_BIT];
            ctrl_q[CTRL_RR_BIT] <= wdata_q[CTRL_RR_BIT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            l0pri_q <= L0PRI_RST;
        else if (entering && ctrl_q[CTRL_RR_BIT] && sel_lvl_q == LVL_L0)
            l0pri_q <= 8'(sel_idx_q) + 8'h01;
        else if (wr_hit(IDX_L0PRI))
            l0pri_q <= wdata_q[7:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            l1vec_q <= L1VEC_RST;
        else if (wr_hit(IDX_L1VEC))
            l1vec_q <= wdata_q[7:0];
    end

    // Entry never touches global enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            core_stat_q <= CORE_STAT_RST;
        else if (wr_hit(IDX_CORE_STAT))
            core_stat_q <= wdata_q[7:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            src_en_q <= '0;
        else if (do_wr && wr_ok && wr_idx == IDX_SRC_EN)
            src_en_q <= (src_en_q & ~wmask[N_SRC-1:0]) | wval[N_SRC-1:0];
    end

    // Write-one clears; a same-cycle event wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_q <= '0;
        else if (do_wr && wr_ok && wr_idx == IDX_FLAGS)
            flags_q <= (flags_q & ~wval[N_SRC-1:0]) | irq_cond;
        else
            flags_q <= flags_q | irq_cond;
    end

endmodule // cip_core_irq_controller

// ==== rtl/cip_pkg.sv ====
package cip_pkg;

    // Register indices; byte address = 4 * index
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_L0PRI = 3'h2;
    localparam logic [2:0] IDX_L1VEC = 3'h3;
    localparam logic [2:0] IDX_CORE_STAT = 3'h4;
    localparam logic [2:0] IDX_SRC_EN = 3'h5;
    localparam logic [2:0] IDX_FLAGS = 3'h6;
    localparam logic [2:0] IDX_ENGINE = 3'h7;
    localparam int REG_COUNT = 8;

    // Field positions
    localparam int CTRL_VSEL_BIT = 6;
    localparam int CTRL_CVT_BIT = 5;
    localparam int CTRL_RR_BIT = 0;
    localparam int STAT_NMI_BIT = 7;
    localparam int STAT_L1_BIT = 1;
    localparam int STAT_L0_BIT = 0;
    localparam int CORE_I_BIT = 7;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] L0PRI_RST = 8'h00;
    localparam logic [7:0] L1VEC_RST = 8'h00;
    localparam logic [7:0] CORE_STAT_RST = 8'h00;

    // Entry and return cycle counts
    localparam int FINISH_CYC = 1;
    localparam int PUSH_CYC = 2;
    localparam int JUMP_LONG_CYC = 3;
    localparam int JUMP_SHORT_CYC = 2;
    localparam int WAKE_EXTRA_CYC = 5;
    localparam int RET_SHORT_CYC = 4;
    localparam int RET_LONG_CYC = 5;
    localparam int SHORT_JUMP_MAX_KB = 8;

    // Compact table vectors
    localparam logic [7:0] CVT_NMI_VEC = 8'h01;
    localparam logic [7:0] CVT_L1_VEC = 8'h02;
    localparam logic [7:0] CVT_L0_VEC = 8'h03;

    // Sleep modes
    localparam logic [1:0] SLP_IDLE = 2'h0;
    localparam logic [1:0] SLP_STANDBY = 2'h1;
    localparam logic [1:0] SLP_PDOWN = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_FINISH = 7'h02,
        ST_WAKE = 7'h04,
        ST_PUSH = 7'h08,
        ST_JUMP = 7'h10,
        ST_RET = 7'h20,
        ST_RESUME = 7'h40
    } cip_state_t;

    typedef enum logic [1:0] {
        LVL_L0 = 2'h0,
        LVL_L1 = 2'h1,
        LVL_NMI = 2'h2
    } cip_level_t;

endpackage

// ==== testbench/cip_monitor.sv ====
`timescale 1ns/1ps
module cip_monitor
    import cip_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic insn_done, // retired
    input wire logic core_sleeping, // asleep
    input wire logic return_from_irq, // return
    input wire logic core_hold, // stall
    input wire logic irq_enter, // entry
    input wire logic [7:0] irq_vector, // vector
    input wire logic [1:0] irq_level // level
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_entry_cycles: assert property ($rose(core_hold) && $past(insn_done) && !$past(core_sleeping)
        |-> core_hold[*5] ##1 (irq_enter && !core_hold)) else $error("entry length wrong");
    a_enter_pulse: assert property (irq_enter |-> !core_hold ##1 !irq_enter) else $error("entry pulse wrong");
    a_return_cycles: assert property ($rose(core_hold) && $past(return_from_irq)
        |-> core_hold[*4] ##1 !core_hold) else $error("return length wrong");
    // Skipping resume brings the stall back early
    a_resume_gap: assert property ($fell(core_hold) && !irq_enter |-> !core_hold[*4]) else $error("no resume");
    a_nmi_vector: assert property (irq_enter && irq_level == LVL_NMI |-> irq_vector == 8'h01)
        else $error("nmi vector wrong");
    a_wake_cycles: assert property ($rose(core_hold) && $past(core_sleeping)
        |-> core_hold[*8] ##1 core_hold[*2] ##1 irq_enter) else $error("wake length wrong");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read twice");
    a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write twice");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
    c_high_level: cover property (irq_enter && irq_level == LVL_L1);
    c_wake: cover property ($rose(core_hold) && $past(core_sleeping));
    c_return: cover property ($rose(core_hold) && $past(return_from_irq));
endmodule // cip_monitor

bind cip_core_irq_controller cip_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .insn_done(insn_done), .core_sleeping(core_sleeping),
    .return_from_irq(return_from_irq), .core_hold(core_hold), .irq_enter(irq_enter),
    .irq_vector(irq_vector), .irq_level(irq_level));

// ==== testbench/cip_core_model.sv ====
`timescale 1ns/1ps
module cip_core_model (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic core_hold, // stall
    input wire logic irq_enter, // entry
    input wire logic ret_go, // ask return
    input wire logic sleep_go, // ask sleep
    input wire logic slow, // three-cycle instructions
    output logic insn_done, // retired
    output logic return_from_irq, // return
    output logic core_sleeping // asleep
);
    logic [1:0] div_q;
    always_ff @(posedge aclk)
    begin
        div_q <= (!aresetn || div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        // A return retires alone
        insn_done <= aresetn && !core_hold && !core_sleeping && !sleep_go && !ret_go && (!slow || div_q == 2'h0);
        return_from_irq <= aresetn && ret_go;
        core_sleeping <= aresetn && (sleep_go || (core_sleeping && !irq_enter));
    end
endmodule // cip_core_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import cip_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, ret_go = 1'b0, sleep_go = 1'b0, slow = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic insn_done, core_sleeping, return_from_irq, core_hold, irq_enter;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, irq_vector;
    logic [31:0] wdata = 32'h0, rdata, rd_q;
    logic [15:0] irq_cond = 16'h0000, handler_addr;
    logic [1:0] bresp, rresp, irq_level, rsp_q;
    int n_fail = 0, total_checks = 0, n_enter = 0;
    always #10 aclk = ~aclk;
    always @(posedge aclk) if (irq_enter === 1'b1) n_enter <= n_enter + 1;
    cip_core_irq_controller #(.BOOT_BASE(16'h1000)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq_cond(irq_cond), .insn_done(insn_done), .core_sleeping(core_sleeping), .sleep_mode(SLP_IDLE),
        .return_from_irq(return_from_irq), .core_hold(core_hold), .irq_enter(irq_enter),
        .handler_addr(handler_addr), .irq_vector(irq_vector), .irq_level(irq_level));
    cip_core_model core_u (.aclk(aclk), .aresetn(aresetn), .core_hold(core_hold), .irq_enter(irq_enter),
        .ret_go(ret_go), .sleep_go(sleep_go), .slow(slow), .insn_done(insn_done),
        .return_from_irq(return_from_irq), .core_sleeping(core_sleeping));
    function automatic logic [7:0] ad(input logic [2:0] i);
        return {3'h0, i, 2'h0};
    endfunction
    task automatic conclude;
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(RESP_OKAY), 32'(bresp));
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd_q = rdata;
        rsp_q = rresp;
        if (a < 8'h20) chk("rdata", e, rd_q);
    endtask
    task automatic cond(input logic [15:0] m);
        @(posedge aclk);
        irq_cond <= m;
        @(posedge aclk);
        irq_cond <= 16'h0000;
    endtask
    task automatic take(input logic [7:0] v, input logic [1:0] l, input logic [15:0] h);
        int n0;
        n0 = n_enter;
        repeat (300) if (n_enter == n0) @(posedge aclk);
        chk("entries", 32'(n0 + 1), 32'(n_enter));
        chk("irq_vector", 32'(v), 32'(irq_vector));
        chk("irq_level", 32'(l), 32'(irq_level));
        chk("handler_addr", 32'(h), 32'(handler_addr));
    endtask
    task automatic quiet;
        int n0;
        n0 = n_enter;
        repeat (40) @(posedge aclk);
        chk("entries", 32'(n0), 32'(n_enter));
    endtask
    // Handler clears its flag first, else it re-enters
    task automatic ret(input logic [15:0] m);
        wr(ad(IDX_FLAGS), {16'h0, m});
        @(posedge aclk);
        ret_go <= 1'b1;
        @(posedge aclk);
        ret_go <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) rc(ad(3'(i)), 32'h0);
        rc(8'h20, 32'h0);
        chk("rresp", 32'(RESP_SLVERR), 32'(rsp_q));
        wr(ad(IDX_L0PRI), 32'h3);
        wr(ad(IDX_L1VEC), 32'h7);
        wr(ad(IDX_SRC_EN), 32'h55);
        wr(ad(IDX_CORE_STAT), 32'h80);
        cond(16'h0014);
        take(8'h05, LVL_L0, 16'h000a);
        rc(ad(IDX_FLAGS), 32'h14);
        ret(16'h0010);
        take(8'h03, LVL_L0, 16'h0006);
        cond(16'h0040);
        take(8'h07, LVL_L1, 16'h000e);
        rc(ad(IDX_STATUS), 32'h3);
        ret(16'h0040);
        rc(ad(IDX_STATUS), 32'h1);
        ret(16'h0004);
        wr(ad(IDX_CORE_STAT), 32'h0);
        cond(16'h0044);
        quiet();
        cond(16'h0003);
        take(8'h01, LVL_NMI, 16'h0002);
        rc(ad(IDX_CORE_STAT), 32'h0);
        wr(ad(IDX_CORE_STAT), 32'h80);
        quiet();
        ret(16'h0001);
        take(8'h07, LVL_L1, 16'h000e);
        ret(16'h0040);
        take(8'h03, LVL_L0, 16'h0006);
        ret(16'h0004);
        wr(ad(IDX_CTRL), 32'h60);
        cond(16'h0010);
        take(8'h03, LVL_L0, 16'h1006);
        ret(16'h0010);
        wr(ad(IDX_CTRL), 32'h1);
        wr(ad(IDX_L0PRI), 32'h0);
        slow <= 1'b1;
        cond(16'h0014);
        take(8'h03, LVL_L0, 16'h0006);
        rc(ad(IDX_L0PRI), 32'h3);
        ret(16'h0004);
        take(8'h05, LVL_L0, 16'h000a);
        ret(16'h0010);
        sleep_go <= 1'b1;
        @(posedge aclk);
        sleep_go <= 1'b0;
        cond(16'h0004);
        take(8'h03, LVL_L0, 16'h0006);
        ret(16'h0004);
        conclude();
    end
    initial
    begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule // tb
